// file: rtl/acs_capability_regs.v
// Port isolation capability registers behind an APB slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "isolation_defs.vh"

module acs_capability_regs #(
  parameter FEATURES = `CAP_FEATURE_COUNT
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire port_upstream_pin,
  input wire init_load_active,
  output reg [FEATURES-1:0] feature_caps,
  output reg [FEATURES-1:0] feature_enables,
  output reg [7:0] egress_vector_size,
  output reg [7:0] egress_port_limit,
  output reg egress_size_valid,
  output reg port_is_upstream
);

  wire setup_phase;
  wire wr_commit;
  wire [4:0] reg_hit;
  wire strap_value;
  wire strap_valid;
  wire [31:0] wmask;
  wire lock_open;
  wire down_port;
  wire lockable_wr;

  reg [11:0] chain_link_reg;
  reg [11:0] chain_link_next;
  reg [FEATURES-1:0] cap_feature_reg;
  reg [7:0] cap_size_reg;
  reg [7:0] cap_size_next;
  reg [FEATURES-1:0] enable_reg;
  reg lock_reg;
  reg [31:0] rd_mux;
  reg [31:0] hdr_word;
  reg [31:0] cap_word;
  reg [31:0] en_word;
  reg [31:0] stat_word;

  // Per-bit reset images of the support and enable fields
  localparam [FEATURES-1:0] CAP_RST = `CAP_FEATURE_RESET;
  localparam [FEATURES-1:0] EN_RST = `ENABLES_RESET;

  // Bus front end
  apb_decode u_decode (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .setup_phase(setup_phase),
    .wr_commit(wr_commit),
    .reg_hit(reg_hit)
  );

  // Port role strap, taken once after reset release
  strap_sync u_strap (
    .pclk(pclk),
    .presetn(presetn),
    .strap_pin(port_upstream_pin),
    .strap_value(strap_value),
    .strap_valid(strap_valid)
  );

  // Byte strobes widened to a bit mask
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Lock opens for the serial loader or by software unlock
  assign lock_open = lock_reg | init_load_active;
  // Until the role is known, treat the port as neither side
  assign down_port = strap_valid & ~strap_value;
  // Only a committed write with the lock open reaches lockable bits
  assign lockable_wr = wr_commit & lock_open; // [R16]

  // Chain link merges write data under the byte mask
  always @* begin
    chain_link_next = chain_link_reg;
    if (lockable_wr && reg_hit[0]) begin
      chain_link_next = (chain_link_reg & ~wmask[`HDR_LINK_MSB:`HDR_LINK_LSB]) |
        (pwdata[`HDR_LINK_MSB:`HDR_LINK_LSB] & wmask[`HDR_LINK_MSB:`HDR_LINK_LSB]); // [R3]
    end
  end

  // Chain link offset; zero ends the chain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_link_reg <= `CHAIN_LINK_RESET; // [R3]
    end else begin
      chain_link_reg <= chain_link_next;
    end
  end

  // One support bit and one enable bit per feature
  genvar gi;
  generate
    for (gi = 0; gi < FEATURES; gi = gi + 1) begin : g_feature
      // Support bit: lockable on downstream ports only
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_feature_reg[gi] <= CAP_RST[gi]; // [R4] [R5] [R6] [R7] [R8] [R9] [R10]
        end else if (lockable_wr && reg_hit[1] && down_port && pstrb[0]) begin
          cap_feature_reg[gi] <= pwdata[gi]; // [R4] [R5] [R6] [R7] [R8] [R9] [R10]
        end
      end

      // Enable bit ignores the support bit on purpose
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enable_reg[gi] <= EN_RST[gi];
        end else if (wr_commit && reg_hit[2] && down_port && pstrb[0]) begin
          enable_reg[gi] <= pwdata[gi]; // [R14]
        end
      end
    end
  endgenerate

  // Vector size write, upper byte of the lower half word
  always @* begin
    cap_size_next = cap_size_reg;
    if (lockable_wr && reg_hit[1] && down_port && pstrb[1]) begin
      cap_size_next = pwdata[`CAP_SIZE_MSB:`CAP_SIZE_LSB]; // [R11]
    end
  end

  // Vector size storage, downstream default sixteen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_size_reg <= `CAP_SIZE_RESET; // [R11]
    end else begin
      cap_size_reg <= cap_size_next;
    end
  end

  // Software unlock; the lock register itself is always writable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= `LOCK_RESET;
    end else if (wr_commit && reg_hit[4] && pstrb[0]) begin
      lock_reg <= pwdata[`LOCK_OPEN_BIT];
    end
  end

  // Read words; upstream masks every support field to zero
  always @* begin
    hdr_word = 32'h00000000;
    hdr_word[`HDR_IDENT_MSB:`HDR_IDENT_LSB] = `STRUCTURE_IDENT_VAL; // [R1]
    hdr_word[`HDR_REV_MSB:`HDR_REV_LSB] = `STRUCTURE_REVISION_VAL; // [R2]
    hdr_word[`HDR_LINK_MSB:`HDR_LINK_LSB] = chain_link_reg; // [R3]
    // Bit 7 and bits above 15 stay zero
    cap_word = 32'h00000000; // [R15]
    if (down_port) begin
      cap_word[FEATURES-1:0] = cap_feature_reg; // [R4] [R5] [R6] [R7] [R8] [R9] [R10]
      cap_word[`CAP_SIZE_MSB:`CAP_SIZE_LSB] = cap_size_reg; // [R11]
    end
    en_word = 32'h00000000;
    if (down_port) begin
      en_word[FEATURES-1:0] = enable_reg; // [R14]
    end
    stat_word = 32'h00000000;
    stat_word[`STAT_UPSTREAM_BIT] = strap_valid & strap_value;
    stat_word[`STAT_LOCK_OPEN_BIT] = lock_open;
    stat_word[`STAT_ROLE_VALID_BIT] = strap_valid;
  end

  // Address mux; unmapped reads return zero
  always @* begin
    case (reg_hit)
      5'h01: rd_mux = hdr_word;
      5'h02: rd_mux = cap_word;
      5'h04: rd_mux = en_word;
      5'h08: rd_mux = stat_word;
      5'h10: rd_mux = {31'h00000000, lock_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data is captured in setup, so it is stable through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      prdata <= rd_mux;
    end
  end

  // Registered views of the effective state for the switch core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feature_caps <= {FEATURES{1'b0}};
      feature_enables <= {FEATURES{1'b0}};
      egress_vector_size <= 8'h00;
      egress_port_limit <= 8'h00;
      egress_size_valid <= 1'b0;
      port_is_upstream <= 1'b0;
    end else begin
      feature_caps <= down_port ? cap_feature_reg : {FEATURES{1'b0}};
      feature_enables <= down_port ? enable_reg : {FEATURES{1'b0}};
      egress_vector_size <= down_port ? cap_size_reg : 8'h00; // [R11]
      // Two vector bits per port, so sixteen gives eight ports
      egress_port_limit <= down_port ? {1'b0, cap_size_reg[7:1]} : 8'h00; // [R12]
      // Size is only meaningful with egress support present
      egress_size_valid <= down_port & cap_feature_reg[`CAP_EGRESS_BIT]; // [R13]
      port_is_upstream <= strap_valid & strap_value;
    end
  end

endmodule

// file: rtl/isolation_defs.vh
// Constants for the port isolation capability register bank
// Operation
// [R1] Header low half reads fixed structure code
// [R2] Header bits 19:16 read fixed version one
// [R3] Header top twelve bits: lockable chain link
// [R4] Cap bit 0: source validation support
// [R5] Cap bit 1: translation blocking support
// [R6] Cap bit 2: request redirect support
// [R7] Cap bit 3: completion redirect support
// [R8] Cap bit 4: upstream forwarding support
// [R9] Cap bit 5: egress control support
// [R10] Cap bit 6: direct translated traffic support
// [R11] Cap bits 15:8: egress vector size
// [R12] Vector size sixteen means eight ports
// [R13] Software ignores size when egress bit clear
// [R14] Downstream enables stay writable regardless of caps
// [R15] Bit 7 and unused bits read zero
// [R16] Lockable fields written only while lock open
`ifndef ISOLATION_DEFS_VH
`define ISOLATION_DEFS_VH

// Register byte offsets
`define OFS_EXT_HEADER 12'h320
`define OFS_FEATURE_CAPS 12'h324
`define OFS_FEATURE_ENABLES 12'h32c
`define OFS_BANK_STATUS 12'h338
`define OFS_LOCK_CTRL 12'h33c

// Header fields
`define HDR_IDENT_LSB 0
`define HDR_IDENT_MSB 15
`define HDR_REV_LSB 16
`define HDR_REV_MSB 19
`define HDR_LINK_LSB 20
`define HDR_LINK_MSB 31
`define STRUCTURE_IDENT_VAL 16'h000d
`define STRUCTURE_REVISION_VAL 4'h1
`define CHAIN_LINK_RESET 12'h000

// Capability fields
`define CAP_FEATURE_COUNT 7
`define CAP_RSVD_BIT 7
`define CAP_SIZE_LSB 8
`define CAP_SIZE_MSB 15
`define CAP_FEATURE_RESET 7'h7f
`define CAP_SIZE_RESET 8'h10
`define CAP_EGRESS_BIT 5

// Enable and lock fields
`define ENABLES_RESET 7'h00
`define LOCK_OPEN_BIT 0
`define LOCK_RESET 1'b0

// Status fields
`define STAT_UPSTREAM_BIT 0
`define STAT_LOCK_OPEN_BIT 1
`define STAT_ROLE_VALID_BIT 2

// Edges after reset release before the role strap is taken
`define STRAP_SETTLE_EDGES 2'h2

`endif

// file: rtl/strap_sync.v
// Role strap synchroniser and one-time capture after reset
`timescale 1ns/1ps
`include "isolation_defs.vh"

module strap_sync (
  input wire pclk,
  input wire presetn,
  input wire strap_pin,
  output reg strap_value,
  output reg strap_valid
);

  reg meta_reg;
  reg sync_reg;
  reg [1:0] settle_reg;

  // Two flops; only sync_reg looks at meta_reg
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= strap_pin;
      sync_reg <= meta_reg;
    end
  end

  // Capture once, after the synchroniser has filled past reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 2'h0;
      strap_value <= 1'b0;
      strap_valid <= 1'b0;
    end else if (!strap_valid) begin
      if (settle_reg == `STRAP_SETTLE_EDGES) begin
        strap_value <= sync_reg;
        strap_valid <= 1'b1;
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

endmodule

// file: rtl/apb_decode.v
// APB address decode, handshake and error answer
`timescale 1ns/1ps
`include "isolation_defs.vh"

module apb_decode (
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  output wire pready,
  output wire pslverr,
  output wire setup_phase,
  output wire wr_commit,
  output wire [4:0] reg_hit
);

  // One-hot select: header, caps, enables, status, lock
  assign reg_hit[0] = (paddr == `OFS_EXT_HEADER);
  assign reg_hit[1] = (paddr == `OFS_FEATURE_CAPS);
  assign reg_hit[2] = (paddr == `OFS_FEATURE_ENABLES);
  assign reg_hit[3] = (paddr == `OFS_BANK_STATUS);
  assign reg_hit[4] = (paddr == `OFS_LOCK_CTRL);

  // No wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup_phase = psel & ~penable;
  // Unmapped addresses answer with an error and change nothing
  assign pslverr = psel & penable & ~(|reg_hit);
  assign wr_commit = psel & penable & pwrite & (|reg_hit);

endmodule

// file: bench/acs_cap_properties.sv
// Checker for the port isolation capability register bank
`timescale 1ns/1ps
module acs_cap_checker #(
  parameter FEATURES = 7
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [FEATURES-1:0] feature_caps,
  input wire [FEATURES-1:0] feature_enables,
  input wire [7:0] egress_vector_size,
  input wire [7:0] egress_port_limit,
  input wire egress_size_valid,
  input wire port_is_upstream
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase and the decoded map
  wire acc = psel && penable;
  wire hit = paddr inside {12'h320, 12'h324, 12'h32c, 12'h338, 12'h33c};
  // Read setup on a chosen place, then its access cycle
  sequence rd_if(c);
    psel && !penable && !pwrite && c ##1 acc;
  endsequence
  // Role held for two edges, so registered lag cannot trip us
  sequence up_held;
    port_is_upstream && $past(port_is_upstream);
  endsequence
  chk_header_fixed: assert property (
    rd_if(paddr == 12'h320) |-> prdata[19:0] == 20'h1000d)
    else $error("header low bits wrong");
  chk_caps_spare_zero: assert property (
    rd_if(paddr == 12'h324) |-> !prdata[7] && prdata[31:16] == 16'h0)
    else $error("caps spare bits set");
  chk_unmapped_read: assert property (rd_if(!hit) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_unmapped_err: assert property (acc |-> pslverr == !hit)
    else $error("error answer wrong");
  chk_up_caps_zero: assert property (
    up_held |-> feature_caps == '0 && egress_vector_size == 8'h0)
    else $error("upstream caps not zero");
  chk_up_enables_zero: assert property (up_held |-> feature_enables == '0)
    else $error("upstream enables not zero");
  // Sixteen vector bits must mean eight ports
  chk_port_limit: assert property (
    egress_vector_size == 8'h10 |-> egress_port_limit == 8'h08)
    else $error("port limit wrong");
  chk_size_valid: assert property (
    $stable(feature_caps) && $stable(port_is_upstream) |->
      egress_size_valid == (feature_caps[5] && !port_is_upstream))
    else $error("size valid wrong");
endmodule

bind acs_capability_regs acs_cap_checker #(.FEATURES(FEATURES)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .feature_caps(feature_caps),
  .feature_enables(feature_enables), .egress_vector_size(egress_vector_size),
  .egress_port_limit(egress_port_limit), .egress_size_valid(egress_size_valid),
  .port_is_upstream(port_is_upstream));

// file: bench/test_acs_capability_regs.sv
// Self-checking bench for the port isolation capability registers
`timescale 1ns/1ps
module test_acs_capability_regs;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] e;
    logic r;
    logic l;
  } row_t;
  row_t rows [21];
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pin = 1'b0;
  logic init = 1'b0;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int num_checks = 0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [6:0] feature_caps;
  wire [6:0] feature_enables;
  wire [7:0] egress_vector_size;
  wire [7:0] egress_port_limit;
  wire egress_size_valid;
  wire port_is_upstream;
  acs_capability_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_upstream_pin(pin),
    .init_load_active(init), .feature_caps(feature_caps), .feature_enables(feature_enables),
    .egress_vector_size(egress_vector_size), .egress_port_limit(egress_port_limit),
    .egress_size_valid(egress_size_valid), .port_is_upstream(port_is_upstream));
  // 20 MHz clock
  always #25 pclk = ~pclk;
  task check_val(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task check_flag(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // Setup then access, held until pready is seen high at an edge
  // Only the watchdog ends a wait that never sees pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Six edges in reset; extra edges let the role strap settle
  task do_reset;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    check_val("caps in reset", 32'h0, 32'(feature_caps));
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    // Downstream port: lock closed, opened, closed, then loader window
    rows = '{'{0, 12'h320, 0, 4'hf, 32'h0001000d, 0, 0}, '{0, 12'h324, 0, 4'hf, 32'h107f, 0, 0},
      '{0, 12'h32c, 0, 4'hf, 0, 0, 0}, '{1, 12'h324, 0, 4'hf, 0, 0, 0},
      '{0, 12'h324, 0, 4'hf, 32'h107f, 0, 0}, '{1, 12'h33c, 1, 4'hf, 0, 0, 0},
      '{1, 12'h324, 32'hffffffa0, 4'hf, 0, 0, 0}, '{0, 12'h324, 0, 4'hf, 32'hff20, 0, 0},
      '{1, 12'h320, 32'habcfffff, 4'hf, 0, 0, 0}, '{0, 12'h320, 0, 4'hf, 32'habc1000d, 0, 0},
      '{1, 12'h32c, 32'h7f, 4'hf, 0, 0, 0}, '{0, 12'h32c, 0, 4'hf, 32'h7f, 0, 0},
      '{1, 12'h324, 32'h1000, 4'h2, 0, 0, 0}, '{0, 12'h324, 0, 4'hf, 32'h1020, 0, 0},
      '{1, 12'h33c, 0, 4'hf, 0, 0, 0}, '{1, 12'h320, 0, 4'hf, 0, 0, 0},
      '{0, 12'h320, 0, 4'hf, 32'habc1000d, 0, 0}, '{0, 12'h300, 0, 4'hf, 0, 1, 0},
      '{1, 12'h324, 32'h107f, 4'hf, 0, 0, 1}, '{1, 12'h324, 0, 4'hf, 0, 0, 0},
      '{0, 12'h324, 0, 4'hf, 32'h107f, 0, 0}};
    do_reset();
    foreach (rows[i]) begin
      init <= rows[i].l;
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
      check_flag("pslverr", rows[i].r, er);
      check_flag("pready", 1'b1, pready);
      if (!rows[i].w)
        check_val("prdata", rows[i].e, rd);
    end
    check_val("caps out", 32'h7f, 32'(feature_caps));
    check_val("enables out", 32'h7f, 32'(feature_enables));
    check_val("port limit", 32'h8, 32'(egress_port_limit));
    check_val("vector size", 32'h10, 32'(egress_vector_size));
    check_flag("size valid", 1'b1, egress_size_valid);
    // Upstream port: caps and enables stay zero even with lock open
    pin <= 1'b1;
    do_reset();
    apb(1'b1, 12'h33c, 32'h1, 4'hf);
    apb(1'b0, 12'h338, 32'h0, 4'hf);
    check_val("status", 32'h7, rd);
    apb(1'b1, 12'h324, 32'hffffffff, 4'hf);
    apb(1'b0, 12'h324, 32'h0, 4'hf);
    check_val("up caps", 32'h0, rd);
    apb(1'b1, 12'h32c, 32'h7f, 4'hf);
    apb(1'b0, 12'h32c, 32'h0, 4'hf);
    check_val("up enables", 32'h0, rd);
    check_flag("role", 1'b1, port_is_upstream);
    check_flag("up size valid", 1'b0, egress_size_valid);
    test_done();
  end
  // Watchdog far beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    test_done();
  end
endmodule
